// >>> rtl/femrx_regs.svh
// Register map, field positions, reset values and frame constants of the receiver.
// Assumes APB byte addresses with one 32-bit word per register.
`ifndef FEMRX_REGS_SVH
`define FEMRX_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define FEMRX_CTRL 12'h000
`define FEMRX_STATION_LO 12'h004
`define FEMRX_STATION_HI 12'h008
`define FEMRX_LONG_MAX 12'h00C
`define FEMRX_LAST_STATUS 12'h010
`define FEMRX_LAST_LEN_PAUSE 12'h014
`define FEMRX_DA_LO 12'h018
`define FEMRX_DA_HI 12'h01C
`define FEMRX_SA_LO 12'h020
`define FEMRX_SA_HI 12'h024

// ****************************************
// Fields and reset values
// ****************************************
`define FEMRX_CTRL_RX_EN 0
`define FEMRX_CTRL_LONG_EN 1
`define FEMRX_CTRL_BITS16 2
`define FEMRX_STATION_RST 48'h0000_0000_0000
`define FEMRX_LONG_MAX_RST 13'h07D0
`define FEMRX_PAUSE_POS 16

// ****************************************
// Frame constants
// ****************************************
`define FEMRX_PRE_NIB 4'h5
`define FEMRX_SFD_NIB 4'hD
`define FEMRX_MIN_PRE_NIBS 4'hF
`define FEMRX_MIN_GAP_NIBS 5'h18
`define FEMRX_MIN_FRAME 13'h0040
`define FEMRX_MAX_FRAME 13'h05EE
`define FEMRX_CTRL_TYPE 16'h8808
`define FEMRX_PAUSE_OPCODE 16'h0001
`define FEMRX_CRC_INIT 32'hFFFF_FFFF
`define FEMRX_CRC_POLY 32'hEDB8_8320
`define FEMRX_CRC_RESIDUE 32'hDEBB_20E3

`endif

// >>> rtl/femrx_pkg.sv
// Types shared by the receiver and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package femrx_pkg;

   typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_DATA, ST_DROP, ST_FLUSH1, ST_FLUSH2,
      ST_STAT} femrx_state_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } femrx_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } femrx_apb_rsp_s;

   typedef struct packed {
      logic rx_clk;
      logic rx_dv;
      logic rx_er;
      logic [3:0] rxd;
   } femrx_mii_s;

   typedef struct packed {
      logic start;
      logic strobe;
      logic envelope;
      logic last;
      logic [1:0] valid_bytes;
      logic [15:0] data;
   } femrx_host_s;

   typedef struct packed {
      logic valid;
      logic rx_ok_flag;
      logic runt_flag;
      logic fcs_bad_flag;
      logic oversize_flag;
      logic jumbo_limit_flag;
      logic odd_nibble_flag;
      logic gap_too_short_flag;
      logic short_preamble_flag;
      logic flow_pause_flag;
      logic false_carrier_flag;
      logic [15:0] pause_time;
      logic [12:0] frame_len;
   } femrx_stat_s;

   typedef struct packed {
      logic bcast;
      logic mcast;
      logic match;
      logic ctrl_frame;
      logic [47:0] captured_da;
      logic [47:0] src_addr;
   } femrx_addr_s;

   typedef struct packed {
      logic rx_en;
      logic long_en;
      logic bits16;
      logic [47:0] station_addr;
      logic [12:0] long_max;
      logic [31:0] prdata;
      logic slverr;
      logic ck1, ck2, ck3, dv1, dv2, er1, er2;
      logic [3:0] d1, d2;
      femrx_state_e fsm;
      logic [3:0] pre_cnt;
      logic [4:0] gap_cnt;
      logic false_car, short_pre, gap_short, er_seen, hi_nib, wide, started, have_word;
      logic [3:0] lo_nib;
      logic [31:0] crc;
      logic [12:0] byte_cnt;
      logic [15:0] etype, opcode, pause_q;
      logic [7:0] acc;
      logic acc_full;
      logic [15:0] word;
      logic [1:0] word_bytes;
      logic done;
      femrx_host_s host;
      femrx_stat_s stat;
      femrx_addr_s addr;
   } femrx_st_s;

endpackage

// >>> rtl/femrx.sv
// Fast Ethernet MAC receive path: MII in, host word strobes and status vector out.
// Assumes i_clk far faster than the MII receive clock and APB from the same i_clk domain.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "femrx_regs.svh"

module femrx_rx (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire femrx_pkg::femrx_apb_req_s i_apb,
   output femrx_pkg::femrx_apb_rsp_s o_apb,
   input wire femrx_pkg::femrx_mii_s i_mii,
   output femrx_pkg::femrx_host_s o_host,
   output femrx_pkg::femrx_stat_s o_stat,
   output femrx_pkg::femrx_addr_s o_addr,
   output logic o_rx_done_pulse
);

   femrx_pkg::femrx_st_s s;
   femrx_pkg::femrx_st_s next_s;
   logic nib_evt;
   logic [7:0] rx_byte;
   logic [47:0] da_next;
   logic [15:0] word_new;
   logic len_over;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h00_0000, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `FEMRX_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic femrx_pkg::femrx_host_s emit(input logic [15:0] d,
      input logic [1:0] nb, input logic first, input logic fin);
      femrx_pkg::femrx_host_s h;
      h.start = first;
      h.strobe = 1'b1;
      h.envelope = 1'b1;
      h.last = fin;
      h.valid_bytes = nb;
      h.data = d;
      return h;
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_s = s;
      rx_byte = {s.d2, s.lo_nib};
      da_next = {s.addr.captured_da[39:0], rx_byte};
      word_new = 16'h0000;
      len_over = 1'b0;
      nib_evt = s.ck3 & ~s.ck2;
      next_s.host.strobe = 1'b0;
      next_s.host.start = 1'b0;
      next_s.host.last = 1'b0;
      next_s.stat.valid = 1'b0;
      next_s.done = 1'b0;
      // Two stages on every MII data and control pin, three on rx_clk; the link clock edge is found after them
      next_s.ck1 = i_mii.rx_clk;
      next_s.ck2 = s.ck1;
      next_s.ck3 = s.ck2;
      next_s.dv1 = i_mii.rx_dv;
      next_s.dv2 = s.dv1;
      next_s.er1 = i_mii.rx_er;
      next_s.er2 = s.er1;
      next_s.d1 = i_mii.rxd;
      next_s.d2 = s.d1;

      // APB: read data captured in setup, write done at the access edge
      if (i_apb.psel && !i_apb.penable) begin
         next_s.slverr = 1'b0;
         next_s.prdata = 32'h0000_0000;
         case (i_apb.paddr)
            `FEMRX_CTRL: next_s.prdata = {29'h0000_0000, s.bits16, s.long_en, s.rx_en};
            `FEMRX_STATION_LO: next_s.prdata = s.station_addr[31:0];
            `FEMRX_STATION_HI: next_s.prdata = {16'h0000, s.station_addr[47:32]};
            `FEMRX_LONG_MAX: next_s.prdata = {19'h0_0000, s.long_max};
            `FEMRX_LAST_STATUS: next_s.prdata = {17'h0_0000, s.addr.bcast, s.addr.mcast,
               s.addr.match, s.addr.ctrl_frame, s.stat.rx_ok_flag, s.stat.runt_flag,
               s.stat.fcs_bad_flag, s.stat.oversize_flag, s.stat.jumbo_limit_flag,
               s.stat.odd_nibble_flag, s.stat.gap_too_short_flag,
               s.stat.short_preamble_flag, s.stat.flow_pause_flag,
               s.stat.false_carrier_flag, s.fsm != femrx_pkg::ST_IDLE};
            `FEMRX_LAST_LEN_PAUSE: next_s.prdata = {s.stat.pause_time, 3'h0, s.stat.frame_len};
            `FEMRX_DA_LO: next_s.prdata = s.addr.captured_da[31:0];
            `FEMRX_DA_HI: next_s.prdata = {16'h0000, s.addr.captured_da[47:32]};
            `FEMRX_SA_LO: next_s.prdata = s.addr.src_addr[31:0];
            `FEMRX_SA_HI: next_s.prdata = {16'h0000, s.addr.src_addr[47:32]};
            default: next_s.slverr = 1'b1;
         endcase
      end
      if (i_apb.psel && i_apb.penable && i_apb.pwrite) begin
         case (i_apb.paddr)
            `FEMRX_CTRL: begin
               next_s.rx_en = i_apb.pwdata[`FEMRX_CTRL_RX_EN];
               next_s.long_en = i_apb.pwdata[`FEMRX_CTRL_LONG_EN];
               next_s.bits16 = i_apb.pwdata[`FEMRX_CTRL_BITS16];
            end
            `FEMRX_STATION_LO: next_s.station_addr[31:0] = i_apb.pwdata;
            `FEMRX_STATION_HI: next_s.station_addr[47:32] = i_apb.pwdata[15:0];
            `FEMRX_LONG_MAX: next_s.long_max = i_apb.pwdata[12:0];
            default: ;
         endcase
      end

      // Receive sequencer, advanced once per sampled nibble up to the flush states, then once per i_clk
      unique case (s.fsm)
         femrx_pkg::ST_IDLE: begin
            if (nib_evt) begin
               if (!s.dv2) begin
                  if (s.gap_cnt != 5'h1F) begin
                     next_s.gap_cnt = s.gap_cnt + 5'h01;
                  end
               end else if (!s.rx_en) begin
                  next_s.fsm = femrx_pkg::ST_DROP;
               end else if (s.d2 == `FEMRX_PRE_NIB) begin
                  next_s.fsm = femrx_pkg::ST_PRE;
                  next_s.pre_cnt = 4'h1;
                  next_s.gap_short = s.gap_cnt < `FEMRX_MIN_GAP_NIBS;
               end else begin
                  next_s.false_car = 1'b1;
                  next_s.fsm = femrx_pkg::ST_DROP;
               end
            end
         end
         femrx_pkg::ST_PRE: begin
            if (nib_evt) begin
               if (!s.dv2) begin
                  next_s.false_car = 1'b1;
                  next_s.gap_cnt = 5'h01;
                  next_s.fsm = femrx_pkg::ST_IDLE;
               end else if (s.d2 == `FEMRX_PRE_NIB) begin
                  if (s.pre_cnt != 4'hF) begin
                     next_s.pre_cnt = s.pre_cnt + 4'h1;
                  end
               end else if (s.d2 == `FEMRX_SFD_NIB) begin
                  next_s.fsm = femrx_pkg::ST_DATA;
                  next_s.short_pre = s.pre_cnt < `FEMRX_MIN_PRE_NIBS;
                  next_s.hi_nib = 1'b0;
                  next_s.crc = `FEMRX_CRC_INIT;
                  next_s.byte_cnt = 13'h0000;
                  next_s.acc_full = 1'b0;
                  next_s.have_word = 1'b0;
                  next_s.started = 1'b0;
                  next_s.er_seen = s.er2;
                  next_s.wide = s.bits16;
                  next_s.etype = 16'h0000;
                  next_s.opcode = 16'h0000;
                  next_s.pause_q = 16'h0000;
                  next_s.addr.ctrl_frame = 1'b0;
               end else begin
                  next_s.false_car = 1'b1;
                  next_s.fsm = femrx_pkg::ST_DROP;
               end
            end
         end
         femrx_pkg::ST_DROP: begin
            if (nib_evt && !s.dv2) begin
               next_s.gap_cnt = 5'h01;
               next_s.fsm = femrx_pkg::ST_IDLE;
            end
         end
         femrx_pkg::ST_DATA: begin
            if (nib_evt) begin
               if (!s.dv2) begin
                  next_s.fsm = femrx_pkg::ST_FLUSH1;
               end else begin
                  next_s.er_seen = s.er_seen | s.er2;
                  next_s.hi_nib = ~s.hi_nib;
                  if (!s.hi_nib) begin
                     next_s.lo_nib = s.d2;
                  end else begin
                     next_s.crc = crc_byte(s.crc, rx_byte);
                     if (s.byte_cnt != 13'h1FFF) begin
                        next_s.byte_cnt = s.byte_cnt + 13'h0001;
                     end
                     if (s.byte_cnt < 13'h0006) begin
                        next_s.addr.captured_da = da_next;
                     end else if (s.byte_cnt < 13'h000C) begin
                        next_s.addr.src_addr = {s.addr.src_addr[39:0], rx_byte};
                     end else if (s.byte_cnt < 13'h000E) begin
                        next_s.etype = {s.etype[7:0], rx_byte};
                     end else if (s.byte_cnt < 13'h0010) begin
                        next_s.opcode = {s.opcode[7:0], rx_byte};
                     end else if (s.byte_cnt < 13'h0012) begin
                        next_s.pause_q = {s.pause_q[7:0], rx_byte};
                     end
                     if (s.byte_cnt == 13'h0005) begin
                        next_s.addr.bcast = &da_next;
                        next_s.addr.mcast = da_next[40] & ~&da_next;
                        next_s.addr.match = da_next == s.station_addr;
                     end
                     if (s.byte_cnt == 13'h000D) begin
                        next_s.addr.ctrl_frame =
                           {s.etype[7:0], rx_byte} == `FEMRX_CTRL_TYPE;
                     end
                     // One word is held back so that the last one can be marked
                     if (!s.wide || s.acc_full) begin
                        word_new = s.wide ? {rx_byte, s.acc} : {8'h00, rx_byte};
                        if (s.have_word) begin
                           next_s.host = emit(s.word, s.word_bytes, !s.started, 1'b0);
                           next_s.started = 1'b1;
                        end
                        next_s.word = word_new;
                        next_s.word_bytes = s.wide ? 2'd2 : 2'd1;
                        next_s.have_word = 1'b1;
                        next_s.acc_full = 1'b0;
                     end else begin
                        next_s.acc = rx_byte;
                        next_s.acc_full = 1'b1;
                     end
                  end
               end
            end
         end
         femrx_pkg::ST_FLUSH1: begin
            if (s.have_word) begin
               next_s.host = emit(s.word, s.word_bytes, !s.started, !s.acc_full);
               next_s.started = 1'b1;
               next_s.have_word = 1'b0;
            end
            next_s.fsm = femrx_pkg::ST_FLUSH2;
         end
         femrx_pkg::ST_FLUSH2: begin
            if (s.acc_full) begin
               next_s.host = emit({8'h00, s.acc}, 2'd1, !s.started, 1'b1);
               next_s.acc_full = 1'b0;
            end
            next_s.fsm = femrx_pkg::ST_STAT;
         end
         femrx_pkg::ST_STAT: begin
            len_over = s.long_en ? (s.byte_cnt > s.long_max) : 1'b0;
            next_s.host.envelope = 1'b0;
            next_s.stat.valid = 1'b1;
            next_s.done = 1'b1;
            next_s.stat.frame_len = s.byte_cnt;
            next_s.stat.runt_flag = !s.addr.captured_da[40] &&
               s.byte_cnt < `FEMRX_MIN_FRAME;
            next_s.stat.fcs_bad_flag = s.crc != `FEMRX_CRC_RESIDUE;
            next_s.stat.oversize_flag = !s.long_en && s.byte_cnt > `FEMRX_MAX_FRAME;
            next_s.stat.jumbo_limit_flag = len_over;
            next_s.stat.odd_nibble_flag = s.hi_nib;
            next_s.stat.gap_too_short_flag = s.gap_short;
            next_s.stat.short_preamble_flag = s.short_pre;
            next_s.stat.false_carrier_flag = s.false_car;
            next_s.stat.flow_pause_flag = s.addr.ctrl_frame &&
               s.opcode == `FEMRX_PAUSE_OPCODE;
            next_s.stat.pause_time = s.pause_q;
            next_s.stat.rx_ok_flag = !(next_s.stat.runt_flag || next_s.stat.fcs_bad_flag ||
               next_s.stat.oversize_flag || len_over || s.hi_nib || s.er_seen);
            next_s.false_car = 1'b0;
            next_s.gap_cnt = 5'h00;
            next_s.fsm = femrx_pkg::ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s <= '0;
         s.station_addr <= `FEMRX_STATION_RST;
         s.long_max <= `FEMRX_LONG_MAX_RST;
         s.gap_cnt <= 5'h1F;
         s.fsm <= femrx_pkg::ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign o_apb.prdata = s.prdata;
   assign o_apb.pslverr = s.slverr & i_apb.psel & i_apb.penable;
   assign o_apb.pready = i_apb.psel & i_apb.penable;
   assign o_host = s.host;
   assign o_stat = s.stat;
   assign o_addr = s.addr;
   assign o_rx_done_pulse = s.done;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_status_one;
      o_stat.valid |=> !o_stat.valid [*8];
   endproperty
   a_status_one: assert property (p_status_one) else $error("status strobe too long");

   property p_done_with_status;
      o_stat.valid == o_rx_done_pulse;
   endproperty
   a_done_with_status: assert property (p_done_with_status)
      else $error("done and status apart");

   property p_ok_clean;
      o_stat.valid && o_stat.rx_ok_flag |-> !(o_stat.fcs_bad_flag || o_stat.runt_flag ||
         o_stat.oversize_flag || o_stat.jumbo_limit_flag || o_stat.odd_nibble_flag);
   endproperty
   a_ok_clean: assert property (p_ok_clean) else $error("success with error");

   property p_runt_len;
      o_stat.valid && o_stat.runt_flag |-> o_stat.frame_len < `FEMRX_MIN_FRAME &&
         !o_addr.captured_da[40];
   endproperty
   a_runt_len: assert property (p_runt_len) else $error("runt flag wrong");

   property p_oversize;
      o_stat.valid && o_stat.oversize_flag |-> o_stat.frame_len > `FEMRX_MAX_FRAME && !s.long_en;
   endproperty
   a_oversize: assert property (p_oversize) else $error("oversize flag wrong");

   property p_pause_ctrl;
      o_stat.valid && o_stat.flow_pause_flag |-> o_addr.ctrl_frame;
   endproperty
   a_pause_ctrl: assert property (p_pause_ctrl) else $error("pause without control");

   property p_start_env;
      o_host.start |-> o_host.strobe && $rose(o_host.envelope);
   endproperty
   a_start_env: assert property (p_start_env) else $error("start without envelope");

   property p_strobe_env;
      o_host.strobe |-> o_host.envelope;
   endproperty
   a_strobe_env: assert property (p_strobe_env) else $error("strobe outside envelope");

   property p_last_end;
      o_host.last |-> o_host.strobe ##[1:2] !o_host.envelope;
   endproperty
   a_last_end: assert property (p_last_end) else $error("envelope after last");

   property p_last_bytes;
      o_host.last |-> o_host.valid_bytes inside {2'd1, 2'd2};
   endproperty
   a_last_bytes: assert property (p_last_bytes) else $error("bad valid byte count");

   property p_narrow;
      o_host.strobe && !s.wide |-> o_host.data[15:8] == 8'h00;
   endproperty
   a_narrow: assert property (p_narrow) else $error("narrow word upper byte set");

   property p_disabled;
      s.fsm == femrx_pkg::ST_IDLE && !s.rx_en |=> s.fsm != femrx_pkg::ST_PRE;
   endproperty
   a_disabled: assert property (p_disabled) else $error("frame started while off");

   c_good: cover property (o_stat.valid && o_stat.rx_ok_flag);
   c_pause: cover property (o_stat.valid && o_stat.flow_pause_flag);
   c_wide_last: cover property (o_host.last && s.wide && o_host.valid_bytes == 2'd1);
   c_carrier: cover property (o_stat.valid && o_stat.false_carrier_flag);

endmodule

// >>> verif/femrx_phy_model.sv
// MII PHY model: sends nibble frames to the receiver.
// Assumes the bench fills frm and then calls send.
`timescale 1ns/1ps
`include "femrx_regs.svh"
module femrx_phy_model (
   output femrx_pkg::femrx_mii_s o_mii
);
   logic [7:0] frm [$];
   // Bench raises this to mark every carried nibble as errored
   logic er_on = 1'b0;
   initial o_mii = '0;
   task automatic nib(input logic dv, input logic [3:0] d);
      o_mii.rx_clk <= 1'b1;
      o_mii.rx_dv <= dv;
      o_mii.rx_er <= dv & er_on;
      // Released data lines must not keep the last value
      o_mii.rxd <= dv ? d : ~o_mii.rxd;
      #62.5 o_mii.rx_clk <= 1'b0;
      #62.5;
   endtask
   // Clock stands still outside send
   task automatic send(input int gap, input int pre, input logic sfd, input logic odd);
      repeat (gap) nib(1'b0, 4'h0);
      repeat (pre) nib(1'b1, `FEMRX_PRE_NIB);
      if (sfd) nib(1'b1, `FEMRX_SFD_NIB);
      foreach (frm[i]) begin
         nib(1'b1, frm[i][3:0]);
         nib(1'b1, frm[i][7:4]);
      end
      if (odd) nib(1'b1, 4'hA);
      repeat (4) nib(1'b0, 4'h0);
   endtask
endmodule

// >>> verif/test_femrx_rx.sv
// Bench for the receiver: APB set-up, PHY frames, host and status checks.
// Assumes femrx_phy_model on the MII side.
`timescale 1ns/1ps
`include "femrx_regs.svh"
module test_femrx_rx;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   femrx_pkg::femrx_apb_req_s apb_q = '0;
   femrx_pkg::femrx_apb_rsp_s apb_r;
   femrx_pkg::femrx_mii_s mii;
   femrx_pkg::femrx_host_s host;
   femrx_pkg::femrx_stat_s stat, st;
   femrx_pkg::femrx_addr_s addr;
   logic done, err, bits16 = 1'b0;
   logic [31:0] rd;
   logic [1:0] last_vb;
   logic [7:0] rxq [$];
   int failures = 0, n_tests = 0, n_st = 0, n_start = 0, n_done = 0, env_bad = 0, cyc = 0;
   localparam logic [47:0] STA = 48'h0012_3456_789A;
   always #2.5 i_clk = ~i_clk;
   femrx_rx dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_apb(apb_q), .o_apb(apb_r),
      .i_mii(mii), .o_host(host), .o_stat(stat), .o_addr(addr), .o_rx_done_pulse(done));
   femrx_phy_model phy_u (.o_mii(mii));
   always @(posedge i_clk) begin
      if (host.strobe === 1'b1) begin
         rxq.push_back(host.data[7:0]);
         if (bits16 && (host.last !== 1'b1 || host.valid_bytes === 2'h2))
            rxq.push_back(host.data[15:8]);
         if (host.start === 1'b1) n_start++;
         if (host.envelope !== 1'b1) env_bad++;
         if (host.last === 1'b1) last_vb = host.valid_bytes;
      end
      if (stat.valid === 1'b1) begin
         st = stat;
         n_st++;
      end
      if (done === 1'b1) n_done++;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         test_done();
      end
   end
   task automatic test_done();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   // Request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge i_clk);
      apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge i_clk);
      apb_q.penable <= 1'b1;
      do @(posedge i_clk); while (apb_r.pready !== 1'b1);
      rd = apb_r.prdata;
      err = apb_r.pslverr;
      apb_q <= '0;
   endtask
   task automatic mk(input logic [47:0] da, input logic [15:0] ty, input logic [31:0] pl,
      input int n, input logic bad);
      logic [31:0] c;
      phy_u.frm.delete();
      for (int i = 0; i < 6; i++) phy_u.frm.push_back(da[47-8*i -: 8]);
      for (int i = 2; i < 8; i++) phy_u.frm.push_back(i[7:0]);
      phy_u.frm.push_back(ty[15:8]);
      phy_u.frm.push_back(ty[7:0]);
      for (int i = 0; i < n; i++) phy_u.frm.push_back(i < 4 ? pl[31-8*i -: 8] : i[7:0]);
      c = 32'hFFFF_FFFF;
      foreach (phy_u.frm[i]) begin
         c = c ^ {24'h00_0000, phy_u.frm[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ `FEMRX_CRC_POLY : c >> 1;
      end
      c = ~c ^ {31'h0000_0000, bad};
      for (int i = 0; i < 4; i++) phy_u.frm.push_back(c[8*i +: 8]);
   endtask
   task automatic run(input int gap, input int pre, input logic sfd, input logic odd);
      rxq.delete();
      n_st = 0;
      n_start = 0;
      n_done = 0;
      phy_u.send(gap, pre, sfd, odd);
      for (int k = 0; k < 200 && n_st == 0; k++) @(posedge i_clk);
      repeat (20) @(posedge i_clk);
   endtask
   task automatic chkq();
      chk("bytes", phy_u.frm.size(), rxq.size());
      foreach (rxq[i]) chk("byte", phy_u.frm[i], rxq[i]);
   endtask
   task automatic t_regs();
      apb(1'b0, `FEMRX_LONG_MAX, 32'h0000_0000);
      chk("long_max", 32'h0000_07D0, rd);
      apb(1'b0, 12'h028, 32'h0000_0000);
      chk("unmapped", 1'b1, err);
   endtask
   task automatic t_off();
      mk(STA, 16'h0800, 32'h0000_0000, 46, 1'b0);
      run(30, 15, 1'b1, 1'b0);
      chk("off_st", 0, n_st);
      chk("off_data", 0, rxq.size());
   endtask
   task automatic t_good();
      apb(1'b1, `FEMRX_STATION_LO, STA[31:0]);
      apb(1'b1, `FEMRX_STATION_HI, {16'h0000, STA[47:32]});
      apb(1'b1, `FEMRX_CTRL, 32'h0000_0001);
      phy_u.frm.delete();
      run(30, 8, 1'b0, 1'b0);
      mk(STA, 16'h0800, 32'h0000_0000, 46, 1'b0);
      run(30, 15, 1'b1, 1'b0);
      chk("n_st", 1, n_st);
      chk("ok", 1'b1, st.rx_ok_flag);
      chk("runt", 1'b0, st.runt_flag);
      chk("fcar", 1'b1, st.false_carrier_flag);
      chk("len", 13'h0040, st.frame_len);
      chk("n_start", 1, n_start);
      chk("env", 0, env_bad);
      chk("vb", 2'h1, last_vb);
      chk("n_done", 1, n_done);
      chk("match", 1'b1, addr.match);
      chk("da", STA, addr.captured_da);
      chk("sa", 48'h0203_0405_0607, addr.src_addr);
      chkq();
   endtask
   task automatic t_runt16();
      apb(1'b1, `FEMRX_CTRL, 32'h0000_0005);
      bits16 = 1'b1;
      mk(STA, 16'h0800, 32'h0000_0000, 43, 1'b0);
      run(10, 10, 1'b1, 1'b0);
      chk("runt", 1'b1, st.runt_flag);
      chk("gap", 1'b1, st.gap_too_short_flag);
      chk("pre", 1'b1, st.short_preamble_flag);
      chk("len", 13'h003D, st.frame_len);
      chk("vb", 2'h1, last_vb);
      chkq();
      bits16 = 1'b0;
   endtask
   task automatic t_bad();
      apb(1'b1, `FEMRX_CTRL, 32'h0000_0001);
      mk(48'hFFFF_FFFF_FFFF, 16'h0800, 32'h0000_0000, 46, 1'b1);
      run(30, 15, 1'b1, 1'b1);
      chk("fcs", 1'b1, st.fcs_bad_flag);
      chk("ok", 1'b0, st.rx_ok_flag);
      chk("odd", 1'b1, st.odd_nibble_flag);
      chk("bcast", 1'b1, addr.bcast);
      chk("runt", 1'b0, st.runt_flag);
      chk("match", 1'b0, addr.match);
   endtask
   task automatic t_pause();
      mk(48'h0180_C200_0001, `FEMRX_CTRL_TYPE, {`FEMRX_PAUSE_OPCODE, 16'h1234}, 46, 1'b0);
      phy_u.er_on = 1'b1;
      run(30, 15, 1'b1, 1'b0);
      phy_u.er_on = 1'b0;
      chk("ok_er", 1'b0, st.rx_ok_flag);
      chk("pause", 1'b1, st.flow_pause_flag);
      chk("ptime", 16'h1234, st.pause_time);
      chk("mcast", 1'b1, addr.mcast);
      chk("bc", 1'b0, addr.bcast);
      chk("ctrl", 1'b1, addr.ctrl_frame);
   endtask
   task automatic t_jumbo();
      apb(1'b1, `FEMRX_LONG_MAX, 32'h0000_0050);
      apb(1'b1, `FEMRX_CTRL, 32'h0000_0003);
      mk(STA, 16'h0800, 32'h0000_0000, 70, 1'b0);
      run(30, 15, 1'b1, 1'b0);
      chk("jumbo", 1'b1, st.jumbo_limit_flag);
      chk("over", 1'b0, st.oversize_flag);
      chk("len", 13'h0058, st.frame_len);
   endtask
   initial begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      t_regs();
      t_off();
      t_good();
      t_runt16();
      t_bad();
      t_pause();
      t_jumbo();
      test_done();
   end
endmodule
